//--- rtl/qdac_pkg.sv
// ---------------------------------------------------------------------
// Shared constants of the quad converter serial load logic.
// ---------------------------------------------------------------------
package qdac_pkg;

    // -----------------------------------------------------------------
    // Serial word layout.
    // -----------------------------------------------------------------
    localparam int CODE_W    = 16;
    localparam int CHAN_W    = 2;
    localparam int NUM_CHAN  = 4;
    localparam int SHIFT_LEN = 19;
    localparam int WORD_W    = 18;
    localparam int CHAN_LSB  = 16;
    localparam int CODE_LSB  = 0;

    // -----------------------------------------------------------------
    // Clear codes.
    // -----------------------------------------------------------------
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_HALF = 16'h8000;

    // -----------------------------------------------------------------
    // Register map, byte addresses on the APB.
    // -----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_WORD     = 8'h08;
    localparam logic [7:0] OFF_ID       = 8'h0C;
    localparam logic [3:0] OFF_INP_PAGE = 4'h1;
    localparam logic [3:0] OFF_DAC_PAGE = 4'h2;

    // Control register bits, both write-one pulses.
    localparam int CTRL_LOAD_BIT  = 0;
    localparam int CTRL_CLEAR_BIT = 1;

    // Status register bits.
    localparam int STAT_CLEAR_BIT = 0;
    localparam int STAT_LOAD_BIT  = 1;
    localparam int STAT_LEVEL_BIT = 2;
    localparam int STAT_CSN_BIT   = 3;
    localparam int STAT_FRAME_LSB = 8;

    // Identification value; the figure is arbitrary.
    localparam logic [31:0] ID_VALUE = 32'h0051_0A2C;

    // -----------------------------------------------------------------
    // Reset values and timing counts.
    // -----------------------------------------------------------------
    localparam logic [18:0] SHIFT_RESET = 19'h0_0000;
    localparam logic [1:0]  POR_CYCLES  = 2'h3;

endpackage

//--- rtl/qdac_link_shift.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Link side shift register, clocked by the host serial clock.
// ---------------------------------------------------------------------
module qdac_link_shift (
    // Link clock and reset
    input  wire logic                link_clk,
    input  wire logic                rst_n,
    // Serial pins
    input  wire logic                cs_n,
    input  wire logic                serial_in,
    output logic                     serial_out,
    // Parallel view for the system domain
    output logic [18:0]              shift_word
);

    typedef struct packed {
        logic [18:0] sr;
    } qdac_link_t;

    qdac_link_t s;
    qdac_link_t next_s;

    // -----------------------------------------------------------------
    // Shift path.
    // -----------------------------------------------------------------
    // The link clock may stop between frames, so reset cannot wait for an
    // edge here and is applied without one.
    always_comb begin
        next_s = s;
        if (!cs_n) begin
            next_s.sr = {s.sr[17:0], serial_in};
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{sr: qdac_pkg::SHIFT_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign serial_out = s.sr[18];
    assign shift_word = s.sr;

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------
    logic [4:0] run;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 5'h00;
        end else if (cs_n) begin
            run <= 5'h00;
        end else if (run != 5'h1F) begin
            run <= run + 5'h01;
        end
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_n);

    a_shift_hold_idle: assert property (cs_n |=> $stable(s.sr))
        else $error("shift register moved while deselected");
    a_shift_bit_in: assert property (
        !cs_n |=> s.sr[0] == $past(serial_in))
        else $error("serial input bit not shifted in");
    a_chain_out_delay: assert property (
        run >= 5'd19 |-> serial_out == $past(serial_in, 19))
        else $error("chain output not delayed by nineteen clocks");
    c_long_frame: cover property (run == 5'd19);

endmodule // qdac_link_shift

//--- rtl/qdac_serial_load.sv
`timescale 1ns/1ps
// What this block does
// - While clear is low every input and converter register takes zero or half scale as the level pin selects.
// - The clear code is taken from the level pin during a clear and at power-on.
// - While select is high the shift register ignores the serial clock and holds.
// - The select rising edge moves the shifted word to an input register and never blocks the load strobe.
// - Each serial input bit is shifted in on the rising serial clock edge while selected.
// - Each bit leaves on the serial output nineteen clock pulses after it entered.
// - While the load strobe is low all four input registers are copied to the converter registers.
module qdac_serial_load (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    input  wire logic        link_clk,
    input  wire logic        cs_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    // Control pins
    input  wire logic        clear_n,
    input  wire logic        level_sel,
    input  wire logic        load_strobe_n,
    // Converter codes
    output logic [15:0]      dac_code_a,
    output logic [15:0]      dac_code_b,
    output logic [15:0]      dac_code_c,
    output logic [15:0]      dac_code_d
);

    // -----------------------------------------------------------------
    // State.
    // -----------------------------------------------------------------
    typedef struct packed {
        logic              cs_m;
        logic              cs_s;
        logic              cs_d;
        logic              clr_m;
        logic              clr_s;
        logic              ld_m;
        logic              ld_s;
        logic              lvl_m;
        logic              lvl_s;
        logic [1:0]        por;
        logic [3:0][15:0]  inp;
        logic [3:0][15:0]  dac;
        logic [17:0]       word;
        logic [7:0]        frames;
        logic              sw_load;
        logic              sw_clear;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } qdac_state_t;

    localparam qdac_state_t ST_RESET = '{
        cs_m:    1'b1,
        cs_s:    1'b1,
        cs_d:    1'b1,
        clr_m:   1'b1,
        clr_s:   1'b1,
        ld_m:    1'b1,
        ld_s:    1'b1,
        por:     qdac_pkg::POR_CYCLES,
        default: '0
    };

    qdac_state_t s;
    qdac_state_t next_s;

    logic [18:0] shift_word;
    logic        clear_act;
    logic        load_act;
    logic        frame_end;
    logic [1:0]  chan;
    logic [15:0] code;

    // -----------------------------------------------------------------
    // Link side.
    // -----------------------------------------------------------------
    qdac_link_shift u_link (
        .link_clk   (link_clk),
        .rst_n      (rst_n),
        .cs_n       (cs_n),
        .serial_in  (serial_in),
        .serial_out (serial_out),
        .shift_word (shift_word)
    );

    // -----------------------------------------------------------------
    // Helpers.
    // -----------------------------------------------------------------
    function automatic logic [15:0] clear_code(input logic lvl);
        return lvl ? qdac_pkg::CODE_HALF : qdac_pkg::CODE_ZERO;
    endfunction

    function automatic logic page_hit(
        input logic [7:0] a,
        input logic [3:0] page
    );
        return a[7:4] == page;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        logic hit;
        hit = (a == qdac_pkg::OFF_CTRL) || (a == qdac_pkg::OFF_STATUS)
              || (a == qdac_pkg::OFF_WORD) || (a == qdac_pkg::OFF_ID)
              || (page_hit(a, qdac_pkg::OFF_INP_PAGE) && a[1:0] == 2'h0)
              || (page_hit(a, qdac_pkg::OFF_DAC_PAGE) && a[1:0] == 2'h0);
        return hit;
    endfunction

    function automatic logic [31:0] read_value(
        input logic [7:0]  a,
        input qdac_state_t st
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == qdac_pkg::OFF_STATUS) begin
            v[qdac_pkg::STAT_CLEAR_BIT] = !st.clr_s;
            v[qdac_pkg::STAT_LOAD_BIT]  = !st.ld_s;
            v[qdac_pkg::STAT_LEVEL_BIT] = st.lvl_s;
            v[qdac_pkg::STAT_CSN_BIT]   = st.cs_s;
            v[qdac_pkg::STAT_FRAME_LSB +: 8] = st.frames;
        end else if (a == qdac_pkg::OFF_WORD) begin
            v[17:0] = st.word;
        end else if (a == qdac_pkg::OFF_ID) begin
            v = qdac_pkg::ID_VALUE;
        end else if (page_hit(a, qdac_pkg::OFF_INP_PAGE)) begin
            v[15:0] = st.inp[a[3:2]];
        end else if (page_hit(a, qdac_pkg::OFF_DAC_PAGE)) begin
            v[15:0] = st.dac[a[3:2]];
        end
        return v;
    endfunction

    // -----------------------------------------------------------------
    // Event decode.
    // -----------------------------------------------------------------
    // The shifted word is sampled only after the synchronised select has
    // risen; select is high by then, so the shift register holds and the word is static.
    assign frame_end = s.cs_s && !s.cs_d;
    assign chan      = shift_word[qdac_pkg::CHAN_LSB +: qdac_pkg::CHAN_W];
    assign code      = shift_word[qdac_pkg::CODE_LSB +: qdac_pkg::CODE_W];
    assign clear_act = !s.clr_s || s.sw_clear || (s.por != 2'h0);
    assign load_act  = !s.ld_s || s.sw_load;

    // -----------------------------------------------------------------
    // Next state.
    // -----------------------------------------------------------------
    always_comb begin
        next_s = s;

        next_s.cs_m  = cs_n;
        next_s.cs_s  = s.cs_m;
        next_s.cs_d  = s.cs_s;
        next_s.clr_m = clear_n;
        next_s.clr_s = s.clr_m;
        next_s.ld_m  = load_strobe_n;
        next_s.ld_s  = s.ld_m;
        next_s.lvl_m = level_sel;
        next_s.lvl_s = s.lvl_m;

        if (s.por != 2'h0) begin
            next_s.por = s.por - 2'h1;
        end

        // Frame transfer into the addressed input register.
        if (frame_end) begin
            next_s.word       = shift_word[17:0];
            next_s.frames     = s.frames + 8'h01;
            next_s.inp[chan]  = code;
        end

        // The strobe acts regardless of select.
        if (load_act) begin
            next_s.dac = s.inp;
        end

        // Clear overrides both paths; the level is read while it acts.
        if (clear_act) begin
            next_s.inp = {4{clear_code(s.lvl_s)}};
            next_s.dac = {4{clear_code(s.lvl_s)}};
        end

        // APB: setup cycle prepares the answer, access cycle completes.
        next_s.sw_load  = 1'b0;
        next_s.sw_clear = 1'b0;
        next_s.pready   = 1'b0;
        next_s.pslverr  = 1'b0;
        if (psel && !penable) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !addr_mapped(paddr);
            next_s.prdata  = (pwrite || !addr_mapped(paddr))
                             ? 32'h0000_0000 : read_value(paddr, s);
        end
        if (psel && penable && s.pready && pwrite
            && paddr == qdac_pkg::OFF_CTRL) begin
            next_s.sw_load  = pwdata[qdac_pkg::CTRL_LOAD_BIT];
            next_s.sw_clear = pwdata[qdac_pkg::CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= ST_RESET;
        end else begin
            s <= next_s;
        end
    end

    // -----------------------------------------------------------------
    // Outputs.
    // -----------------------------------------------------------------
    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign dac_code_a = s.dac[0];
    assign dac_code_b = s.dac[1];
    assign dac_code_c = s.dac[2];
    assign dac_code_d = s.dac[3];

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_clear_zero_code: assert property (
        clear_act && !s.lvl_s |=> s.inp == '0 && s.dac == '0)
        else $error("clear with level low did not zero registers");

    a_clear_half_code: assert property (
        clear_act && s.lvl_s |=>
            s.inp == {4{16'h8000}} && s.dac == {4{16'h8000}})
        else $error("clear with level high did not give half scale");

    a_por_level_take: assert property (
        s.por != 2'h0 |=> s.dac[0] == clear_code($past(s.lvl_s)))
        else $error("power-on code not taken from level pin");

    a_load_copy_all: assert property (
        !s.ld_s && !clear_act |=> s.dac == $past(s.inp))
        else $error("load strobe did not copy input registers");

    a_frame_to_input: assert property (
        frame_end && !clear_act |=>
            s.inp[$past(chan)] == $past(code))
        else $error("select rise did not update addressed register");

    a_input_hold_quiet: assert property (
        !frame_end && !clear_act |=> $stable(s.inp))
        else $error("input register changed without a frame");

    a_apb_ready_once: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");

    a_apb_err_flag: assert property (
        psel && !penable && !addr_mapped(paddr) |=>
            pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_apb_ok_flag: assert property (
        psel && !penable && addr_mapped(paddr) |=> !pslverr)
        else $error("mapped access flagged as error");

    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without a setup cycle");

    a_ctrl_load_take: assert property (
        psel && penable && pready && pwrite
            && paddr == qdac_pkg::OFF_CTRL
            && pwdata[qdac_pkg::CTRL_LOAD_BIT] |=> s.sw_load)
        else $error("control write did not request a load");

    a_ctrl_clear_take: assert property (
        psel && penable && pready && pwrite
            && paddr == qdac_pkg::OFF_CTRL
            && pwdata[qdac_pkg::CTRL_CLEAR_BIT] |=> s.sw_clear)
        else $error("control write did not request a clear");

    a_clear_over_load: assert property (
        !s.clr_s && !s.ld_s |=>
            s.dac == {4{clear_code($past(s.lvl_s))}})
        else $error("load strobe overrode clear");

    a_clear_over_frame: assert property (
        frame_end && clear_act |=>
            s.inp == {4{clear_code($past(s.lvl_s))}})
        else $error("frame overrode clear");

    a_load_while_sel: assert property (
        !s.ld_s && !s.cs_s && !clear_act |=> s.dac == $past(s.inp))
        else $error("select blocked the load strobe");

    a_dac_hold_quiet: assert property (
        !load_act && !clear_act |=> $stable(s.dac))
        else $error("converter register changed without load");

    a_frame_count: assert property (
        frame_end |=> s.frames == $past(s.frames) + 8'h01)
        else $error("frame counter did not step");

    a_word_capture: assert property (
        frame_end |=> s.word == $past(shift_word[17:0]))
        else $error("captured word differs from shifted word");

    a_chan_a_kept: assert property (
        frame_end && !clear_act && chan != 2'h0 |=> $stable(s.inp[0]))
        else $error("channel A changed for another address");

    a_chan_b_kept: assert property (
        frame_end && !clear_act && chan != 2'h1 |=> $stable(s.inp[1]))
        else $error("channel B changed for another address");

    a_chan_c_kept: assert property (
        frame_end && !clear_act && chan != 2'h2 |=> $stable(s.inp[2]))
        else $error("channel C changed for another address");

    a_chan_d_kept: assert property (
        frame_end && !clear_act && chan != 2'h3 |=> $stable(s.inp[3]))
        else $error("channel D changed for another address");

    a_sw_pulse_short: assert property (s.sw_load |=> !s.sw_load)
        else $error("control load request lasted two cycles");

    c_frame_seen: cover property (frame_end && !clear_act);
    c_load_seen:  cover property (!s.ld_s && !s.cs_s);
    c_half_clear: cover property (!s.clr_s && s.lvl_s);
    c_soft_clear: cover property (s.sw_clear);

endmodule // qdac_serial_load

//--- tb/qdac_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Host end of the serial link; its clock runs inside frames and, from idle_edges, also while deselected.
// ---------------------------------------------------------------------
module qdac_host_model (
    // Serial pins
    output logic      link_clk,
    output logic      cs_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    logic so_seen [0:63];

    initial begin
        link_clk  = 1'b0;
        cs_n      = 1'b1;
        serial_in = 1'b0;
    end

    // Bit n-1 goes out first; the output is sampled half a period on.
    task automatic send(input logic [63:0] bits, input int n);
        // The offset keeps select changes off the system clock edges.
        #3;
        cs_n = 1'b0;
        #7.5;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            #7.5 link_clk = 1'b1;
            #7.5 so_seen[n - 1 - i] = serial_out;
            link_clk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        // A released line must not keep showing the last bit as valid.
        serial_in = ~serial_in;
        #100;
    endtask

    task automatic idle_edges(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            #7.5 link_clk = 1'b1;
            #7.5 link_clk = 1'b0;
        end
    endtask
endmodule // qdac_host_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        link_clk;
    logic        cs_n;
    logic        serial_in;
    logic        serial_out;
    logic        clear_n;
    logic        level_sel;
    logic        load_strobe_n;
    logic [15:0] dac_code_a;
    logic [15:0] dac_code_b;
    logic [15:0] dac_code_c;
    logic [15:0] dac_code_d;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        so_last;
    logic [63:0] pat;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;

    qdac_serial_load dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(link_clk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out), .clear_n(clear_n), .level_sel(level_sel),
        .load_strobe_n(load_strobe_n), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .dac_code_c(dac_code_c),
        .dac_code_d(dac_code_d));
    qdac_host_model host (.link_clk(link_clk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out));

    // -----------------------------------------------------------------
    // Clock, timeout and closing report.
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Bus and pin helpers.
    // -----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // The wait is cut short only by the global cycle ceiling.
        do @(posedge clock); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd_data)
    endtask

    task automatic dacs(input logic [15:0] e);
        `CHK("dac_code_a", e, dac_code_a)
        `CHK("dac_code_b", e, dac_code_b)
        `CHK("dac_code_c", e, dac_code_c)
        `CHK("dac_code_d", e, dac_code_d)
    endtask

    task automatic clear_pulse(input logic lvl, input logic [15:0] e);
        level_sel <= lvl;
        repeat (4) @(posedge clock);
        clear_n <= 1'b0;
        repeat (5) @(posedge clock);
        dacs(e);
        rd(8'h14, {16'h0000, e}, "input b clear");
        clear_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        clear_n = 1'b1;
        level_sel = 1'b1;
        load_strobe_n = 1'b1;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        dacs(16'h8000);
        rd(8'h0C, qdac_pkg::ID_VALUE, "id");
        apb(1'b0, 8'h30, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, rd_err)
        `CHK("unmapped data", 32'h0000_0000, rd_data)
        apb(1'b0, 8'h12, 32'h0000_0000);
        `CHK("misaligned err", 1'b1, rd_err)
        `CHK("misaligned data", 32'h0000_0000, rd_data)
        host.send(64'h0000_0000_0001_1234, 18);
        repeat (8) @(posedge clock);
        rd(8'h14, 32'h0000_1234, "input b");
        rd(8'h10, 32'h0000_8000, "input a");
        `CHK("dac b held", 16'h8000, dac_code_b)
        // Nineteen filler bits, then a word for channel D.
        pat = {27'h000_0000, 19'h5_A3C9, 18'h3_BEEF};
        host.send(pat, 37);
        for (int j = 18; j < 37; j++) begin
            `CHK("serial_out", pat[54 - j], host.so_seen[j])
        end
        repeat (8) @(posedge clock);
        rd(8'h1C, 32'h0000_BEEF, "input d");
        so_last = serial_out;
        host.idle_edges(6);
        `CHK("serial_out idle", so_last, serial_out)
        rd(8'h08, 32'h0003_BEEF, "word idle");
        // Load strobe pulsed while the select line is low.
        fork
            host.send(64'h0000_0000_0000_0F0F, 18);
            begin
                repeat (2) @(posedge clock);
                load_strobe_n <= 1'b0;
                repeat (5) @(posedge clock);
                load_strobe_n <= 1'b1;
            end
        join
        repeat (6) @(posedge clock);
        `CHK("dac b load", 16'h1234, dac_code_b)
        `CHK("dac d load", 16'hBEEF, dac_code_d)
        `CHK("dac a before", 16'h8000, dac_code_a)
        rd(8'h10, 32'h0000_0F0F, "input a");
        apb(1'b1, qdac_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock);
        `CHK("dac a ctrl", 16'h0F0F, dac_code_a)
        rd(8'h20, 32'h0000_0F0F, "dac a page");
        rd(qdac_pkg::OFF_STATUS, 32'h0000_030C, "status");
        apb(1'b1, qdac_pkg::OFF_CTRL, 32'h0000_0002);
        repeat (4) @(posedge clock);
        dacs(16'h8000);
        clear_pulse(1'b0, 16'h0000);
        clear_pulse(1'b1, 16'h8000);
        test_done();
    end
endmodule // testbench
